// ==== verilog/srh_cfg.svh ====
// Constants of the status reporting hierarchy
// Included by the package and the design modules
`ifndef SRH_CFG_SVH
`define SRH_CFG_SVH
`define SRH_REG_W    16
`define SRH_STB_W    8
`define SRH_OP_W     4
`define SRH_STB_ERRQ 2
`define SRH_STB_QUES 3
`define SRH_STB_MAV  4
`define SRH_STB_ESB  5
`define SRH_STB_MSS  6
`define SRH_STB_OPER 7
`define SRH_MSS_IGN  8'hBF
`define SRH_Z16      16'h0000
`define SRH_Z8       8'h00
`define SRH_Z2       2'h0
`endif

// ==== verilog/srh_pkg.sv ====
// Types of the status reporting hierarchy
// Needs srh_cfg.svh on the include path
`include "srh_cfg.svh"
package srh_pkg;
    typedef enum logic [`SRH_OP_W-1:0] {
        SRH_OP_COND_Q = 4'h0,
        SRH_OP_RISE_W = 4'h1,
        SRH_OP_RISE_Q = 4'h2,
        SRH_OP_FALL_W = 4'h3,
        SRH_OP_FALL_Q = 4'h4,
        SRH_OP_EVNT_Q = 4'h5,
        SRH_OP_ENAB_W = 4'h6,
        SRH_OP_ENAB_Q = 4'h7,
        SRH_OP_STB_Q  = 4'h8,
        SRH_OP_SRE_W  = 4'h9,
        SRH_OP_SRE_Q  = 4'hA,
        SRH_OP_ESR_Q  = 4'hB,
        SRH_OP_ESE_W  = 4'hC,
        SRH_OP_ESE_Q  = 4'hD
    } srh_op_t;
    typedef enum logic {
        SRH_SEL_OPER = 1'b0,
        SRH_SEL_QUES = 1'b1
    } srh_sel_t;
endpackage

// ==== verilog/srh_scpi_reg.sv ====
// One five-part status register: condition, two edge filters,
// latched events and enable, with its sum bit.
// Condition input is already in the clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
`include "srh_cfg.svh"
module srh_scpi_reg
    import srh_pkg::*;
#(
    parameter int W = `SRH_REG_W
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] cond_in,
    input  wire logic         wr_rise,
    input  wire logic         wr_fall,
    input  wire logic         wr_enab,
    input  wire logic [W-1:0] wdata,
    input  wire logic         rd_event,
    output logic      [W-1:0] cond,
    output logic      [W-1:0] rise_filter_bit,
    output logic      [W-1:0] fall_filter_bit,
    output logic      [W-1:0] events,
    output logic      [W-1:0] enable,
    output logic              sum
);
    // Top bit of every part stays zero
    localparam logic [W-1:0] KEEP = {1'b0, {(W-1){1'b1}}};

    logic [W-1:0] cond_r, cond_nxt, prev_r, prev_nxt;
    logic [W-1:0] rise_r, rise_nxt, fall_r, fall_nxt;
    logic [W-1:0] event_r, event_nxt, enab_r, enab_nxt;
    logic [W-1:0] rise_hit, fall_hit;

    always_comb begin
        cond_nxt  = cond_in & KEEP;
        prev_nxt  = cond_r;
        rise_hit  = cond_r & ~prev_r & rise_r;
        fall_hit  = ~cond_r & prev_r & fall_r;
        rise_nxt  = wr_rise ? (wdata & KEEP) : rise_r;
        fall_nxt  = wr_fall ? (wdata & KEEP) : fall_r;
        enab_nxt  = wr_enab ? (wdata & KEEP) : enab_r;
        // New hits win over the clearing read
        event_nxt = (rd_event ? '0 : event_r) | rise_hit | fall_hit;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cond_r  <= '0;
            prev_r  <= '0;
            rise_r  <= KEEP;
            fall_r  <= '0;
            event_r <= '0;
            enab_r  <= '0;
        end else begin
            cond_r  <= cond_nxt;
            prev_r  <= prev_nxt;
            rise_r  <= rise_nxt;
            fall_r  <= fall_nxt;
            event_r <= event_nxt;
            enab_r  <= enab_nxt;
        end
    end

    assign cond            = cond_r;
    assign rise_filter_bit = rise_r;
    assign fall_filter_bit = fall_r;
    assign events          = event_r;
    assign enable          = enab_r;
    assign sum             = |(event_r & enab_r);

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_RISE_SETS: assert property (
        (rise_hit != '0) |=> ((event_r & $past(rise_hit)) == $past(rise_hit)))
        else $error("filtered rising edge not latched");
    AST_FALL_SETS: assert property (
        (fall_hit != '0) |=> ((event_r & $past(fall_hit)) == $past(fall_hit)))
        else $error("filtered falling edge not latched");
    AST_ONLY_FILTERED: assert property (
        1'b1 |=> ((event_r & ~$past(event_r) & ~$past(rise_hit) & ~$past(fall_hit)) == '0))
        else $error("event bit set without filtered edge");
    AST_HIT_ON_CLEAR: assert property (
        rd_event |=> (event_r == ($past(rise_hit) | $past(fall_hit))))
        else $error("clearing read lost or kept wrong bits");
    AST_TOP_ZERO: assert property (
        !cond_r[W-1] && !rise_r[W-1] && !fall_r[W-1] && !event_r[W-1] && !enab_r[W-1])
        else $error("top bit of a part is set");
    AST_COND_FOLLOWS: assert property (
        1'b1 |=> (cond_r == ($past(cond_in) & KEEP)))
        else $error("condition part does not follow inputs");
    AST_ENAB_HOLD: assert property (
        !wr_enab |=> $stable(enab_r))
        else $error("enable part changed without a write");
    COV_RISE_EVENT: cover property (rise_hit != '0 ##1 rd_event);
endmodule
`default_nettype wire

// ==== verilog/srh_srq_gen.sv ====
// Master summary and service request from the status byte bits.
// stb_in is the next status byte; mss aligns with it, srq is registered and aligns with the status byte.
`timescale 1ns/100ps
`default_nettype none
`include "srh_cfg.svh"
module srh_srq_gen
    import srh_pkg::*;
(
    input  wire logic [`SRH_STB_W-1:0] stb_in,
    input  wire logic [`SRH_STB_W-1:0] sre,
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    output logic                       mss,
    output logic                       srq
);
    logic [`SRH_STB_W-1:0] prev_r, prev_nxt, live;
    logic                  srq_r, srq_nxt;

    always_comb begin
        live     = stb_in & sre & `SRH_MSS_IGN;
        prev_nxt = stb_in;
        srq_nxt  = |(live & ~prev_r);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prev_r <= `SRH_Z8;
            srq_r  <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            srq_r  <= srq_nxt;
        end
    end

    assign mss = |live;
    assign srq = srq_r;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_SRQ_CAUSE: assert property (
        srq_r |-> (($past(stb_in) & ~$past(prev_r) & $past(sre) & `SRH_MSS_IGN) != '0))
        else $error("service request without enabled rising bit");
    COV_SRQ: cover property (srq_r);
endmodule
`default_nettype wire

// ==== verilog/srh_top.sv ====
// Status reporting hierarchy: operation and questionable registers,
// event status register, status byte, service request enable and
// the command port through which the remote controller queries it.
// Assumes a command parser on clk_sys; only the condition inputs may be async.
`timescale 1ns/100ps
`default_nettype none
`include "srh_cfg.svh"
module srh_top
    import srh_pkg::*;
#(
    parameter int W = `SRH_REG_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic [W-2:0]          oper_cond_in,
    input  wire logic [W-2:0]          ques_cond_in,
    input  wire logic [`SRH_STB_W-1:0] esr_event_in,
    input  wire logic                  msg_avail,
    input  wire logic                  err_queue_busy,
    input  wire logic                  cmd_valid,
    input  wire logic [`SRH_OP_W-1:0]  cmd_op,
    input  wire logic                  cmd_sel,
    input  wire logic [W-1:0]          cmd_wdata,
    input  wire logic                  poll_req,
    output logic                       rsp_valid,
    output logic                       rsp_err,
    output logic      [W-1:0]          rsp_data,
    output logic                       poll_valid,
    output logic      [`SRH_STB_W-1:0] poll_stb,
    output logic      [`SRH_STB_W-1:0] status_byte,
    output logic                       srq
);
    localparam int SW = 2 * (W - 1);

    ////////////////////////////////////////////////////////////////
    // Three-stage synchroniser; a bit moves once stages two and
    // three agree, which filters a one-cycle glitch.
    logic [SW-1:0] s1_r, s2_r, s3_r, acc_r;
    logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt, acc_nxt;

    always_comb begin
        s1_nxt  = {ques_cond_in, oper_cond_in};
        s2_nxt  = s1_r;
        s3_nxt  = s2_r;
        acc_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & acc_r);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            acc_r <= '0;
        end else begin
            s1_r  <= s1_nxt;
            s2_r  <= s2_nxt;
            s3_r  <= s3_nxt;
            acc_r <= acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Operation and questionable registers
    logic [1:0][W-1:0] cond_v, rise_v, fall_v, evnt_v, enab_v, cin_v;
    logic [1:0]        sum_v, wr_rise, wr_fall, wr_enab, rd_evnt;

    // Operation bit 0 is the calibration status input
    assign cin_v[SRH_SEL_OPER] = {1'b0, acc_r[W-2:0]};
    assign cin_v[SRH_SEL_QUES] = {1'b0, acc_r[SW-1:W-1]};

    for (genvar g = 0; g < 2; g++) begin : g_reg
        srh_scpi_reg #(.W(W)) u_reg (
            .clk_sys         (clk_sys),
            .rst_b           (rst_b),
            .cond_in         (cin_v[g]),
            .wr_rise         (wr_rise[g]),
            .wr_fall         (wr_fall[g]),
            .wr_enab         (wr_enab[g]),
            .wdata           (cmd_wdata),
            .rd_event        (rd_evnt[g]),
            .cond            (cond_v[g]),
            .rise_filter_bit (rise_v[g]),
            .fall_filter_bit (fall_v[g]),
            .events          (evnt_v[g]),
            .enable          (enab_v[g]),
            .sum             (sum_v[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    // Event status register: events latch, a query clears
    logic [`SRH_STB_W-1:0] esr_r, esr_nxt, ese_r, ese_nxt;
    logic [`SRH_STB_W-1:0] sre_r, sre_nxt;
    logic                  rd_esr, esb;

    assign esb = |(esr_r & ese_r);

    ////////////////////////////////////////////////////////////////
    // Status byte and service request
    logic [`SRH_STB_W-1:0] stb_r, stb_nxt, stb_raw;
    logic                  mss;

    always_comb begin
        stb_raw                = `SRH_Z8;
        stb_raw[`SRH_STB_ERRQ] = err_queue_busy;
        stb_raw[`SRH_STB_QUES] = sum_v[SRH_SEL_QUES];
        stb_raw[`SRH_STB_MAV]  = msg_avail;
        stb_raw[`SRH_STB_ESB]  = esb;
        stb_raw[`SRH_STB_OPER] = sum_v[SRH_SEL_OPER];
        stb_nxt                = stb_raw;
        stb_nxt[`SRH_STB_MSS]  = mss;
    end

    srh_srq_gen u_srq (
        .stb_in  (stb_raw),
        .sre     (sre_r),
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .mss     (mss),
        .srq     (srq)
    );

    ////////////////////////////////////////////////////////////////
    // Command decode; set commands give no answer, queries answer
    // one cycle later, unknown codes answer with rsp_err.
    srh_op_t         op;
    logic            rsp_valid_r, rsp_valid_nxt, rsp_err_r, rsp_err_nxt;
    logic [W-1:0]    rsp_data_r, rsp_data_nxt;
    logic            poll_valid_r, poll_valid_nxt;
    logic [`SRH_STB_W-1:0] poll_stb_r, poll_stb_nxt;

    assign op = srh_op_t'(cmd_op);

    always_comb begin
        wr_rise        = `SRH_Z2;
        wr_fall        = `SRH_Z2;
        wr_enab        = `SRH_Z2;
        rd_evnt        = `SRH_Z2;
        rd_esr         = 1'b0;
        sre_nxt        = sre_r;
        ese_nxt        = ese_r;
        rsp_valid_nxt  = 1'b0;
        rsp_err_nxt    = 1'b0;
        rsp_data_nxt   = rsp_data_r;
        poll_valid_nxt = poll_req;
        poll_stb_nxt   = poll_req ? stb_r : poll_stb_r;
        if (cmd_valid) begin
            unique case (op)
                SRH_OP_COND_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = cond_v[cmd_sel];
                end
                SRH_OP_RISE_W: begin
                    wr_rise[cmd_sel] = 1'b1;
                end
                SRH_OP_RISE_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = rise_v[cmd_sel];
                end
                SRH_OP_FALL_W: begin
                    wr_fall[cmd_sel] = 1'b1;
                end
                SRH_OP_FALL_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = fall_v[cmd_sel];
                end
                SRH_OP_EVNT_Q: begin
                    rsp_valid_nxt    = 1'b1;
                    rsp_data_nxt     = evnt_v[cmd_sel];
                    rd_evnt[cmd_sel] = 1'b1;
                end
                SRH_OP_ENAB_W: begin
                    wr_enab[cmd_sel] = 1'b1;
                end
                SRH_OP_ENAB_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = enab_v[cmd_sel];
                end
                SRH_OP_STB_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {`SRH_Z8, stb_r};
                end
                SRH_OP_SRE_W: begin
                    sre_nxt = cmd_wdata[`SRH_STB_W-1:0];
                end
                SRH_OP_SRE_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {`SRH_Z8, sre_r};
                end
                SRH_OP_ESR_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {`SRH_Z8, esr_r};
                    rd_esr        = 1'b1;
                end
                SRH_OP_ESE_W: begin
                    ese_nxt = cmd_wdata[`SRH_STB_W-1:0];
                end
                SRH_OP_ESE_Q: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {`SRH_Z8, ese_r};
                end
                default: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_err_nxt   = 1'b1;
                    rsp_data_nxt  = `SRH_Z16;
                end
            endcase
        end
        // Arriving events win over the clearing query
        esr_nxt = (rd_esr ? `SRH_Z8 : esr_r) | esr_event_in;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            esr_r        <= `SRH_Z8;
            ese_r        <= `SRH_Z8;
            sre_r        <= `SRH_Z8;
            stb_r        <= `SRH_Z8;
            rsp_valid_r  <= 1'b0;
            rsp_err_r    <= 1'b0;
            rsp_data_r   <= `SRH_Z16;
            poll_valid_r <= 1'b0;
            poll_stb_r   <= `SRH_Z8;
        end else begin
            esr_r        <= esr_nxt;
            ese_r        <= ese_nxt;
            sre_r        <= sre_nxt;
            stb_r        <= stb_nxt;
            rsp_valid_r  <= rsp_valid_nxt;
            rsp_err_r    <= rsp_err_nxt;
            rsp_data_r   <= rsp_data_nxt;
            poll_valid_r <= poll_valid_nxt;
            poll_stb_r   <= poll_stb_nxt;
        end
    end

    assign rsp_valid   = rsp_valid_r;
    assign rsp_err     = rsp_err_r;
    assign rsp_data    = rsp_data_r;
    assign poll_valid  = poll_valid_r;
    assign poll_stb    = poll_stb_r;
    assign status_byte = stb_r;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_SUMS_TO_STB: assert property (
        1'b1 |=> (stb_r[`SRH_STB_OPER] == $past(sum_v[0]))
                 && (stb_r[`SRH_STB_QUES] == $past(sum_v[1])))
        else $error("register sum bit not passed to status byte");
    AST_ESB: assert property (
        1'b1 |=> (stb_r[`SRH_STB_ESB] == |($past(esr_r) & $past(ese_r))))
        else $error("event status summary wrong");
    AST_MSS: assert property (
        stb_r[`SRH_STB_MSS] == |(stb_r & $past(sre_r) & `SRH_MSS_IGN))
        else $error("master summary does not match enabled bits");
    AST_MAV: assert property (
        1'b1 |=> (stb_r[`SRH_STB_MAV] == $past(msg_avail)))
        else $error("message available bit wrong");
    AST_SRQ_ON_RISE: assert property (
        ($rose(stb_r[`SRH_STB_OPER]) && $past(sre_r[`SRH_STB_OPER])) |-> srq)
        else $error("no service request on enabled rise");
    AST_SRE_BACK: assert property (
        (cmd_valid && op == SRH_OP_SRE_W) ##1 (cmd_valid && op == SRH_OP_SRE_Q)
        |=> rsp_valid && (rsp_data[`SRH_STB_W-1:0] == $past(cmd_wdata[`SRH_STB_W-1:0], 2)))
        else $error("request mask read back differs");
    AST_QUERY_ANSWERED: assert property (
        (cmd_valid && op inside {SRH_OP_COND_Q, SRH_OP_EVNT_Q, SRH_OP_STB_Q})
        |=> rsp_valid && !rsp_err)
        else $error("query not answered");
    AST_POLL: assert property (
        poll_req |=> poll_valid && (poll_stb == $past(stb_r)))
        else $error("serial poll returned wrong byte");
    AST_RESET_CLEAN: assert property (disable iff (1'b0)
        !rst_b |=> (sre_r == `SRH_Z8) && !srq && (esr_r == `SRH_Z8))
        else $error("state not cleared by reset");
    COV_EVNT_QUERY: cover property (cmd_valid && op == SRH_OP_EVNT_Q && evnt_v[0] != '0);
    COV_POLL_MSS: cover property (poll_req && stb_r[`SRH_STB_MSS]);
    COV_ESR_QUERY: cover property (cmd_valid && op == SRH_OP_ESR_Q && esr_r != '0);
endmodule
`default_nettype wire

// ==== testbench/srh_ctrl_model.sv ====
// Remote controller model: issues commands and takes the answers
// Assumes the one-cycle answer latency of the command port
`timescale 1ns/100ps
`default_nettype none
module srh_ctrl_model
    import srh_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_err,
    input  wire logic [15:0] rsp_data,
    output logic             cmd_valid,
    output logic [3:0]       cmd_op,
    output logic             cmd_sel,
    output logic [15:0]      cmd_wdata
);
    initial begin
        cmd_valid = 1'h0;
        cmd_op    = 4'h0;
        cmd_sel   = 1'h0;
        cmd_wdata = 16'h0000;
    end
    // One command, called just after an edge; the answer is read after the
    // taking edge, so calls may follow back to back
    task automatic send(input logic [3:0] op, input logic sel, input logic [15:0] wd,
                        output logic [16:0] rd);
        cmd_valid <= 1'h1;
        cmd_op    <= op;
        cmd_sel   <= sel;
        cmd_wdata <= wd;
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        cmd_wdata <= ~wd; // Released data must not look valid
        #1;
        rd = rsp_valid ? {rsp_err, rsp_data} : 17'h1FFFF;
    endtask
endmodule
`default_nettype wire

// ==== testbench/test_status_reporting_hierarchy.sv ====
// Bench for the status reporting hierarchy
// Status inputs driven here; commands go through the controller model
`timescale 1ns/100ps
`default_nettype none
module test_status_reporting_hierarchy;
    import srh_pkg::*;
    logic        clk_sys, rst_b = 1'h0, poll_req = 1'h0;
    logic        msg_avail = 1'h0, err_queue_busy = 1'h0;
    logic [14:0] oper_cond_in = 15'h0000, ques_cond_in = 15'h0000;
    logic [14:0] rf, ff, a, b, o, en, ev;
    logic [7:0]  esr_event_in = 8'h00, status_byte, poll_stb;
    logic        cmd_valid, cmd_sel, rsp_valid, rsp_err, poll_valid, srq;
    logic [3:0]  cmd_op;
    logic [15:0] cmd_wdata, rsp_data, wd;
    logic [16:0] rd;
    int          fail_count = 0, n_checks = 0, srq_cnt = 0;
    srh_top dut_u (.clk_sys, .rst_b, .oper_cond_in, .ques_cond_in, .esr_event_in, .msg_avail,
        .err_queue_busy, .cmd_valid, .cmd_op, .cmd_sel, .cmd_wdata, .poll_req, .rsp_valid,
        .rsp_err, .rsp_data, .poll_valid, .poll_stb, .status_byte, .srq);
    srh_ctrl_model ctl_u (.clk_sys, .rsp_valid, .rsp_err, .rsp_data, .cmd_valid, .cmd_op,
        .cmd_sel, .cmd_wdata);
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (srq === 1'h1) srq_cnt <= srq_cnt + 1;
    function automatic logic [14:0] exp_ev(input logic [14:0] r, f, p, n);
        return (r & n & ~p) | (f & p & ~n);
    endfunction
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic q(input logic [3:0] op, input logic sel, input logic [16:0] exp);
        ctl_u.send(op, sel, 16'h0000, rd);
        chk(rd, exp);
    endtask
    task automatic w(input logic [3:0] op, input logic sel, input logic [15:0] d);
        ctl_u.send(op, sel, d, rd);
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        void'($urandom(91));
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'h1;
        cyc(2);
        for (int s = 0; s < 2; s++) begin
            q(SRH_OP_RISE_Q, s[0], 17'h07FFF);
            q(SRH_OP_FALL_Q, s[0], 17'h00000);
            q(SRH_OP_ENAB_Q, s[0], 17'h00000);
            q(SRH_OP_EVNT_Q, s[0], 17'h00000);
        end
        q(SRH_OP_SRE_Q, 1'h0, 17'h00000);
        // Write opcodes sit one below their queries; top bit must read zero
        for (int i = 0; i < 12; i++) begin
            wd = (i == 0) ? 16'hFFFF : 16'($urandom);
            a = 15'((i % 3 == 2) ? SRH_OP_ENAB_W : (i % 3 == 1) ? SRH_OP_FALL_W : SRH_OP_RISE_W);
            w(a[3:0], i[0], wd);
            q(a[3:0] + 4'h1, i[0], {2'h0, wd[14:0]});
        end
        w(SRH_OP_SRE_W, 1'h0, 16'h00C0);
        q(SRH_OP_SRE_Q, 1'h0, 17'h000C0);
        q(4'hE, 1'h0, 17'h10000);
        for (int i = 0; i < 6; i++) begin
            rf = $urandom;
            ff = $urandom;
            en = $urandom;
            a = $urandom;
            b = $urandom;
            w(SRH_OP_RISE_W, 1'h1, {1'h0, rf});
            w(SRH_OP_FALL_W, 1'h1, {1'h0, ff});
            w(SRH_OP_ENAB_W, 1'h1, {1'h0, en});
            w(SRH_OP_EVNT_Q, 1'h1, 16'h0000);
            o = ques_cond_in;
            @(posedge clk_sys);
            ques_cond_in <= a;
            cyc(10);
            @(posedge clk_sys);
            ques_cond_in <= b;
            cyc(10);
            ev = exp_ev(rf, ff, o, a) | exp_ev(rf, ff, a, b);
            chk(status_byte[3], |(ev & en));
            q(SRH_OP_COND_Q, 1'h1, {2'h0, b});
            q(SRH_OP_EVNT_Q, 1'h1, {2'h0, ev});
        end
        w(SRH_OP_RISE_W, 1'h0, 16'h0001);
        w(SRH_OP_FALL_W, 1'h0, 16'h0001);
        w(SRH_OP_ENAB_W, 1'h0, 16'h0001);
        w(SRH_OP_EVNT_Q, 1'h0, 16'h0000);
        chk(srq_cnt, 17'h00000);
        @(posedge clk_sys);
        oper_cond_in <= 15'h0001;
        cyc(10);
        q(SRH_OP_COND_Q, 1'h0, 17'h00001);
        chk(status_byte, 17'h000C0);
        chk(srq_cnt, 17'h00001);
        @(posedge clk_sys);
        poll_req <= 1'h1;
        @(posedge clk_sys);
        poll_req <= 1'h0;
        #1;
        chk({poll_valid, poll_stb}, 17'h001C0);
        q(SRH_OP_STB_Q, 1'h0, 17'h000C0);
        q(SRH_OP_EVNT_Q, 1'h0, 17'h00001);
        q(SRH_OP_EVNT_Q, 1'h0, 17'h00000);
        cyc(2);
        chk(status_byte, 17'h00000);
        @(posedge clk_sys);
        oper_cond_in <= 15'h0000;
        cyc(10);
        chk(status_byte, 17'h000C0);
        @(posedge clk_sys);
        msg_avail <= 1'h1;
        err_queue_busy <= 1'h1;
        cyc(3);
        chk(status_byte, 17'h000D4);
        w(SRH_OP_ESE_W, 1'h0, 16'h0001);
        q(SRH_OP_ESE_Q, 1'h0, 17'h00001);
        @(posedge clk_sys);
        esr_event_in <= 8'h01;
        @(posedge clk_sys);
        esr_event_in <= 8'h00;
        cyc(3);
        chk(status_byte, 17'h000F4);
        chk(srq_cnt, 17'h00002);
        q(SRH_OP_ESR_Q, 1'h0, 17'h00001);
        q(SRH_OP_ESR_Q, 1'h0, 17'h00000);
        cyc(2);
        chk(status_byte, 17'h000D4);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
